// [hdl/snap_pkg.sv]
package snap_pkg;

   // Register offsets seen on the serial port (address bit 7 marks a write)
   localparam logic [6:0] MOTION_RESET_ADDR = 7'h12;
   localparam logic [6:0] SNAPSHOT_ADDR = 7'h13;
   localparam logic [6:0] FW_CTRL_ADDR = 7'h14;
   localparam int ADDR_WR_BIT = 7;

   // Command codes
   localparam logic [7:0] SNAPSHOT_START = 8'h83;
   localparam logic [7:0] FW_DL_ARM = 8'h1d;
   localparam logic [7:0] FW_DL_GO = 8'h18;
   localparam logic [7:0] FW_CRC_START = 8'h15;

   // Reset and idle read values
   localparam logic [7:0] SNAPSHOT_RESET = 8'h00;
   localparam logic [7:0] FW_CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Capture geometry
   localparam int RAM_AW = 11;
   localparam int CAPTURE_PIXELS = 1536;
   localparam logic [RAM_AW-1:0] LAST_PIXEL = 11'h5ff;

   // Timing
   localparam int CLK_MHZ = 125;
   localparam int CRC_WAIT_US = 7000;
   localparam int CRC_WAIT_CYCLES = CRC_WAIT_US * CLK_MHZ;
   localparam int CRC_CW = 20;

   typedef struct packed
   {
      logic frame_start;
      logic valid;
      logic [7:0] data;
   } pixel_t;

   typedef struct packed
   {
      logic [6:0] addr;
      logic [7:0] data;
   } reg_write_t;

   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'b00,
      ENG_FETCH = 2'b01,
      ENG_PUSH = 2'b11
   } engine_t;

   typedef struct packed
   {
      logic [7:0] sh;
      logic wr;
      logic [6:0] addr;
      reg_write_t wr_word;
      logic wr_tgl;
      logic rd_tgl;
      logic [6:0] rd_addr;
      logic ack_tgl;
   } link_t;

endpackage

// [hdl/pixel_ram.sv]
`timescale 1ns/1ps
module pixel_ram #(
   parameter int AW = 11,
   parameter int W = 8
)
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic re_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [W-1:0] rdata_o
);

   // No reset: contents are undefined until a capture fills them
   logic [W-1:0] mem [2**AW];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      if (re_i)
      begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule

// [hdl/skid2.sv]
`timescale 1ns/1ps
module skid2 #(
   parameter int W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);

   typedef struct packed
   {
      logic [1:0] count;
      logic head;
      logic [1:0][W-1:0] slot;
   } fifo_t;

   fifo_t q;
   fifo_t next_q;
   logic push;
   logic pop;

   assign in_ready_o = (q.count != 2'd2);
   assign out_valid_o = (q.count != 2'd0);
   assign out_data_o = q.slot[q.head];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      next_q = q;
      if (push)
      begin
         next_q.slot[q.head ^ q.count[0]] = in_data_i;
      end
      if (pop)
      begin
         next_q.head = ~q.head;
      end
      next_q.count = q.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

endmodule

// [hdl/motion_clear_pixel_dump_fw_ctrl.sv]
`timescale 1ns/1ps
module motion_clear_pixel_dump_fw_ctrl #(
   parameter int CRC_WAIT = snap_pkg::CRC_WAIT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sclk_i,
   input wire logic ncs_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   input snap_pkg::pixel_t pixel_i,
   input wire logic burst_req_i,
   output logic burst_ready_o,
   output logic motion_clear_o,
   output logic nav_halt_o,
   output logic fw_download_o,
   output logic crc_busy_o
);

   typedef struct packed
   {
      logic [2:0] wr_sync;
      logic [2:0] rd_sync;
      logic [2:0] ack_sync;
      snap_pkg::engine_t eng;
      logic eng_zero;
      logic [7:0] push_data;
      logic [snap_pkg::RAM_AW-1:0] ptr;
      logic [snap_pkg::RAM_AW-1:0] cap_cnt;
      logic cap_arm;
      logic cap_run;
      logic cap_ready;
      logic nav_halt;
      logic dl_armed;
      logic dl_active;
      logic [snap_pkg::CRC_CW-1:0] crc_cnt;
      logic crc_busy;
      logic crc_frame;
      logic motion_clear;
      logic [7:0] hold_data;
      logic hold_full;
   } core_t;

   localparam logic [snap_pkg::CRC_CW-1:0] CRC_LOAD =
      snap_pkg::CRC_CW'(CRC_WAIT - 1);

   logic [1:0] rst_q;
   logic rst_n;
   core_t s;
   core_t next_s;
   snap_pkg::link_t link;
   snap_pkg::link_t next_link;
   logic [3:0] bit_cnt;
   logic [7:0] link_sh;
   logic wr_event;
   logic rd_event;
   logic ack_event;
   logic pixel_req;
   logic ram_re;
   logic ram_we;
   logic [7:0] ram_rdata;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [7:0] buf_out_data;

   function automatic logic toggled(input logic [2:0] sync);
      toggled = sync[1] ^ sync[2];
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_q <= 2'b00;
      end
      else
      begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // Link side: mode 3, bits sampled on rising sclk, MSB first
   always_ff @(posedge sclk_i or posedge ncs_i)
   begin
      if (ncs_i)
      begin
         bit_cnt <= 4'h0;
      end
      else
      begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   assign link_sh = {link.sh[6:0], mosi_i};

   always_comb
   begin
      next_link = link;
      next_link.sh = link_sh;
      if (bit_cnt == 4'd7)
      begin
         next_link.addr = link_sh[6:0];
         next_link.wr = link_sh[snap_pkg::ADDR_WR_BIT];
         if (!link_sh[snap_pkg::ADDR_WR_BIT])
         begin
            next_link.rd_addr = link_sh[6:0];
            next_link.rd_tgl = ~link.rd_tgl;
         end
      end
      if (bit_cnt == 4'd15)
      begin
         if (link.wr)
         begin
            next_link.wr_word.addr = link.addr;
            next_link.wr_word.data = link_sh;
            next_link.wr_tgl = ~link.wr_tgl;
         end
         else
         begin
            next_link.ack_tgl = ~link.ack_tgl;
         end
      end
   end

   // Toggles survive ncs so no false event is seen across frames
   always_ff @(posedge sclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link <= '0;
      end
      else
      begin
         link <= next_link;
      end
   end

   // Held byte is stable: the controller waits after the address byte
   always_ff @(negedge sclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         miso_o <= 1'b0;
      end
      else
      begin
         miso_o <= s.hold_data[3'd7 - bit_cnt[2:0]];
      end
   end
   assign miso_oe_o = ~ncs_i & ~link.wr & bit_cnt[3];

   // Core side
   assign wr_event = toggled(s.wr_sync);
   assign rd_event = toggled(s.rd_sync);
   assign ack_event = toggled(s.ack_sync);
   assign pixel_req = (rd_event && link.rd_addr == snap_pkg::SNAPSHOT_ADDR)
      || burst_req_i;
   assign burst_ready_o = (s.eng == snap_pkg::ENG_IDLE) & ~rd_event;
   assign ram_re = (s.eng == snap_pkg::ENG_IDLE) & pixel_req & s.cap_ready;
   assign ram_we = s.cap_run & pixel_i.valid;
   assign buf_in_valid = (s.eng == snap_pkg::ENG_PUSH);
   assign buf_out_ready = ~s.hold_full;

   always_comb
   begin
      next_s = s;
      next_s.wr_sync = {s.wr_sync[1:0], link.wr_tgl};
      next_s.rd_sync = {s.rd_sync[1:0], link.rd_tgl};
      next_s.ack_sync = {s.ack_sync[1:0], link.ack_tgl};
      next_s.motion_clear = 1'b0;

      // Self-check: timed wait, then the end of one more frame
      // Ahead of the command decode so a new start in the same cycle wins
      if (s.crc_busy)
      begin
         if (s.crc_cnt != '0)
         begin
            next_s.crc_cnt = s.crc_cnt - 1'b1;
         end
         else if (pixel_i.frame_start)
         begin
            if (s.crc_frame)
            begin
               next_s.crc_busy = 1'b0;
            end
            next_s.crc_frame = 1'b1;
         end
      end

      if (wr_event)
      begin
         case (link.wr_word.addr)
            snap_pkg::MOTION_RESET_ADDR:
            begin
               next_s.motion_clear = 1'b1;
            end
            snap_pkg::SNAPSHOT_ADDR:
            begin
               // Written byte is decoded only, never kept
               next_s.nav_halt = 1'b1;
               next_s.cap_ready = 1'b0;
               next_s.dl_active = 1'b0;
               next_s.cap_run = 1'b0;
               next_s.cap_arm =
                  (link.wr_word.data == snap_pkg::SNAPSHOT_START);
            end
            snap_pkg::FW_CTRL_ADDR:
            begin
               next_s.dl_armed =
                  (link.wr_word.data == snap_pkg::FW_DL_ARM);
               if (link.wr_word.data == snap_pkg::FW_DL_GO && s.dl_armed)
               begin
                  next_s.dl_active = 1'b1;
               end
               if (link.wr_word.data == snap_pkg::FW_CRC_START)
               begin
                  next_s.crc_busy = 1'b1;
                  next_s.crc_cnt = CRC_LOAD;
                  next_s.crc_frame = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end

      // Capture starts on the next frame so the data is a complete frame
      if (s.cap_arm && pixel_i.frame_start)
      begin
         next_s.cap_arm = 1'b0;
         next_s.cap_run = 1'b1;
         next_s.cap_cnt = '0;
      end
      if (ram_we)
      begin
         next_s.cap_cnt = s.cap_cnt + 1'b1;
         if (s.cap_cnt == snap_pkg::LAST_PIXEL)
         begin
            next_s.cap_run = 1'b0;
            next_s.cap_ready = 1'b1;
            next_s.ptr = '0;
         end
      end

      // Read engine
      case (s.eng)
         snap_pkg::ENG_IDLE:
         begin
            if (pixel_req && s.cap_ready)
            begin
               next_s.eng = snap_pkg::ENG_FETCH;
            end
            else if (pixel_req || rd_event)
            begin
               // Write-only and not-ready reads answer zero
               next_s.push_data = snap_pkg::READ_ZERO;
               next_s.eng_zero = 1'b1;
               next_s.eng = snap_pkg::ENG_PUSH;
            end
         end
         snap_pkg::ENG_FETCH:
         begin
            next_s.push_data = ram_rdata;
            next_s.eng_zero = 1'b0;
            next_s.eng = snap_pkg::ENG_PUSH;
         end
         snap_pkg::ENG_PUSH:
         begin
            // Stalls here while the buffer is full
            if (buf_in_ready)
            begin
               if (!s.eng_zero)
               begin
                  next_s.ptr = (s.ptr == snap_pkg::LAST_PIXEL) ?
                     '0 : s.ptr + 1'b1;
               end
               next_s.eng = snap_pkg::ENG_IDLE;
            end
         end
         default:
         begin
            next_s.eng = snap_pkg::ENG_IDLE;
         end
      endcase

      // Byte handed to the link is freed when its last bit has gone out
      if (ack_event)
      begin
         next_s.hold_full = 1'b0;
      end
      if (buf_out_valid && buf_out_ready)
      begin
         next_s.hold_data = buf_out_data;
         next_s.hold_full = 1'b1;
      end
   end

   // Only hardware reset ends a pixel-capture halt
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.hold_data <= snap_pkg::SNAPSHOT_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign motion_clear_o = s.motion_clear;
   assign nav_halt_o = s.nav_halt | s.crc_busy;
   assign fw_download_o = s.dl_active;
   assign crc_busy_o = s.crc_busy;

   pixel_ram #(
      .AW(snap_pkg::RAM_AW),
      .W(8)
   ) u_ram (
      .clk_i(clk_i),
      .we_i(ram_we),
      .waddr_i(s.cap_cnt),
      .wdata_i(pixel_i.data),
      .re_i(ram_re),
      .raddr_i(s.ptr),
      .rdata_o(ram_rdata)
   );

   skid2 #(
      .W(8)
   ) u_buf (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .in_valid_i(buf_in_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(s.push_data),
      .out_valid_o(buf_out_valid),
      .out_ready_i(buf_out_ready),
      .out_data_o(buf_out_data)
   );

endmodule

// [bench/snap_monitor.sv]
`timescale 1ns/1ps
module snap_monitor #(
   parameter int CRC_WAIT = 50
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sclk_i,
   input wire logic ncs_i,
   input wire logic mosi_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input snap_pkg::pixel_t pixel_i,
   input wire logic burst_req_i,
   input wire logic burst_ready_o,
   input wire logic motion_clear_o,
   input wire logic nav_halt_o,
   input wire logic fw_download_o,
   input wire logic crc_busy_o
);
   int busy_cnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         busy_cnt <= 0;
      else
         busy_cnt <= crc_busy_o ? busy_cnt + 1 : 0;
   end
   clear_pulse_a: assert property (motion_clear_o |=> !motion_clear_o)
      else $error("motion clear longer than one cycle");
   clear_isolate_a: assert property (motion_clear_o |->
      $stable(fw_download_o) && $stable(nav_halt_o))
      else $error("motion clear disturbed other state");
   // Halt drops with the check in the same cycle; the first idle cycle is skipped as well
   halt_sticky_a: assert property (nav_halt_o && !crc_busy_o &&
      !$past(crc_busy_o) |=> nav_halt_o)
      else $error("navigation resumed without reset");
   crc_halt_a: assert property (crc_busy_o && $past(crc_busy_o)
      |-> nav_halt_o)
      else $error("navigation running during check");
   crc_length_a: assert property ($fell(crc_busy_o)
      |-> busy_cnt >= CRC_WAIT)
      else $error("check ended too early");
   dl_drop_a: assert property ($fell(fw_download_o)
      |-> ##[0:1] nav_halt_o)
      else $error("download dropped without capture");
   burst_busy_a: assert property (burst_req_i && burst_ready_o
      |=> !burst_ready_o)
      else $error("burst engine ready while fetching");
   // Output turns on only after the address byte, while the clock stands high
   oe_select_a: assert property ($rose(miso_oe_o) |-> !ncs_i && sclk_i)
      else $error("miso driven while deselected");
   cover property ($rose(crc_busy_o));
   cover property ($rose(fw_download_o));
   cover property (motion_clear_o);
   cover property (burst_req_i && burst_ready_o);
endmodule
bind motion_clear_pixel_dump_fw_ctrl snap_monitor #(.CRC_WAIT(CRC_WAIT)) mon (
   .clk_i, .rst_n_i, .sclk_i, .ncs_i, .mosi_i, .miso_o, .miso_oe_o,
   .pixel_i, .burst_req_i, .burst_ready_o, .motion_clear_o, .nav_halt_o,
   .fw_download_o, .crc_busy_o);

// [bench/serial_master.sv]
`timescale 1ns/1ps
module serial_master
(
   output logic sclk_o,
   output logic ncs_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic miso_oe_i
);
   initial
   begin
      sclk_o = 1'b1;
      ncs_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Mode 3 frame; clock stands high outside frames
   task automatic xfer(input logic wr, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] r);
      logic [15:0] sh;
      sh = {wr, a, d};
      r = 8'h00;
      ncs_o <= 1'b0;
      #100;
      for (int i = 15; i >= 0; i--)
      begin
         if (i == 7 && !wr)
            #1000;
         sclk_o <= 1'b0;
         mosi_o <= sh[i];
         #24;
         // Undriven miso reads as unknown so a missing byte never matches
         if (i < 8)
            r[i] = miso_oe_i ? miso_i : 1'bx;
         sclk_o <= 1'b1;
         #24;
      end
      mosi_o <= ~sh[0];
      ncs_o <= 1'b1;
      #1000;
   endtask
endmodule

// [bench/motion_clear_pixel_dump_fw_ctrl_tb.sv]
`timescale 1ns/1ps
module motion_clear_pixel_dump_fw_ctrl_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic burst_req_i = 1'b0;
   snap_pkg::pixel_t pixel_i = '0;
   logic sclk_i, ncs_i, mosi_i, miso_o, miso_oe_o, burst_ready_o;
   logic motion_clear_o, nav_halt_o, fw_download_o, crc_busy_o;
   logic [7:0] salt = 8'h00;
   logic [7:0] r;
   int n_errors = 0;
   int total_checks = 0;
   int n_clr = 0;
   int pcnt = 0;
   int acc;
   motion_clear_pixel_dump_fw_ctrl #(.CRC_WAIT(50)) dut (.clk_i, .rst_n_i,
      .sclk_i, .ncs_i, .mosi_i, .miso_o, .miso_oe_o, .pixel_i, .burst_req_i,
      .burst_ready_o, .motion_clear_o, .nav_halt_o, .fw_download_o,
      .crc_busy_o);
   serial_master m (.sclk_o(sclk_i), .ncs_o(ncs_i), .mosi_o(mosi_i),
      .miso_i(miso_o), .miso_oe_i(miso_oe_o));
   initial
      forever #4 clk_i = ~clk_i;
   function automatic logic [7:0] pix(input int k);
      return k[7:0] ^ salt;
   endfunction
   // Frame of 1600 pixels, so one capture never spans a frame boundary
   always @(posedge clk_i)
   begin
      pcnt <= (pcnt == 1600) ? 0 : pcnt + 1;
      pixel_i.frame_start <= (pcnt == 0);
      pixel_i.valid <= (pcnt != 0);
      pixel_i.data <= pix(pcnt - 1);
      if (motion_clear_o === 1'b1)
         n_clr <= n_clr + 1;
   end
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_flag(input logic e, input logic g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      m.xfer(1'b1, a, d, r);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      m.xfer(1'b0, a, 8'h00, r);
      chk_byte(e, r);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #400000;
      n_errors++;
      complete_run;
   end
   initial
   begin
      void'($urandom(32'h432df965));
      salt = 8'($urandom);
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk_flag(1'b0, nav_halt_o);
      rd(snap_pkg::SNAPSHOT_ADDR, snap_pkg::SNAPSHOT_RESET);
      rd(snap_pkg::MOTION_RESET_ADDR, snap_pkg::READ_ZERO);
      rd(7'h7f, snap_pkg::READ_ZERO);
      $display("reset test done");
      repeat (3) wr(snap_pkg::MOTION_RESET_ADDR, 8'($urandom));
      chk_byte(8'h03, 8'(n_clr));
      chk_flag(1'b0, nav_halt_o);
      $display("motion clear test done");
      wr(snap_pkg::FW_CTRL_ADDR, snap_pkg::FW_CRC_START);
      chk_flag(1'b1, crc_busy_o);
      chk_flag(1'b1, nav_halt_o);
      // Port left idle while the check runs
      for (int i = 0; i < 5000 && crc_busy_o !== 1'b0; i++)
         @(posedge clk_i);
      @(negedge clk_i);
      chk_flag(1'b0, nav_halt_o);
      $display("self-check test done");
      wr(snap_pkg::FW_CTRL_ADDR, snap_pkg::FW_DL_GO);
      chk_flag(1'b0, fw_download_o);
      wr(snap_pkg::FW_CTRL_ADDR, snap_pkg::FW_DL_ARM);
      repeat (1700) @(posedge clk_i);
      wr(snap_pkg::FW_CTRL_ADDR, snap_pkg::FW_DL_GO);
      chk_flag(1'b1, fw_download_o);
      $display("download test done");
      wr(snap_pkg::SNAPSHOT_ADDR, snap_pkg::SNAPSHOT_START);
      chk_flag(1'b1, nav_halt_o);
      chk_flag(1'b0, fw_download_o);
      rd(snap_pkg::SNAPSHOT_ADDR, snap_pkg::READ_ZERO);
      repeat (4000) @(posedge clk_i);
      for (int k = 0; k < 8; k++)
         rd(snap_pkg::SNAPSHOT_ADDR, pix(k));
      wr(snap_pkg::SNAPSHOT_ADDR, snap_pkg::SNAPSHOT_START);
      repeat (4000) @(posedge clk_i);
      rd(snap_pkg::SNAPSHOT_ADDR, pix(0));
      rd(snap_pkg::SNAPSHOT_ADDR, pix(1));
      chk_flag(1'b1, nav_halt_o);
      $display("capture test done");
      // Request held high: each cycle with ready high takes one pixel
      acc = 0;
      @(posedge clk_i);
      burst_req_i <= 1'b1;
      repeat (12)
      begin
         @(negedge clk_i);
         acc += int'(burst_ready_o === 1'b1);
         @(posedge clk_i);
      end
      burst_req_i <= 1'b0;
      @(negedge clk_i);
      chk_flag(1'b0, burst_ready_o);
      // Hold byte, two buffer slots and the stalled engine
      chk_byte(8'd4, 8'(acc));
      rd(snap_pkg::SNAPSHOT_ADDR, pix(2));
      @(negedge clk_i);
      chk_flag(1'b1, burst_ready_o);
      rd(snap_pkg::SNAPSHOT_ADDR, pix(3));
      $display("buffer test done");
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk_flag(1'b0, nav_halt_o);
      chk_flag(1'b0, fw_download_o);
      rd(snap_pkg::SNAPSHOT_ADDR, snap_pkg::READ_ZERO);
      $display("second reset test done");
      complete_run;
   end
endmodule
